// file: rtl/ftp_regs.sv
/*
 * Flash timing parameter register bank: five software-written counts that
 * set program and erase phase durations for the flash sequencer.
 * Assumes a single-cycle strobe register port on core_clk (10 MHz) and a
 * sequencer that pulses op_start when a program or erase operation begins.
 */
// Implementation choice: the strobed register port.
// Summary of operation
// RL1: 8-bit phase A count at 0x108, reset 0xb4
// RL2: software sets phase A per oscillator frequency
// RL3: 11-bit phase B count at 0x10c, reset 0x6c0
// RL4: software sets phase B per oscillator frequency
// RL5: 8-bit phase C count at 0x110, reset 0xb4
// RL6: software sets phase C per oscillator frequency
// RL7: 17-bit page erase count at 0x114
// RL8: software sets page erase per oscillator frequency
// RL9: 17-bit bulk erase count at 0x118
// RL10: reserved bits read zero, writes ignored
// RL11: counts sampled when an operation starts
`timescale 1ns/1ps
`default_nettype none
`include "ftp_consts.svh"

module ftp_regs
    import ftp_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic [`FTP_ADDR_W-1:0]     reg_addr,
    input  wire logic [`FTP_DATA_W-1:0]     reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [`FTP_DATA_W-1:0]     reg_rdata,
    input  wire logic                       op_start,
    output logic      [`FTP_PHASE_A_W-1:0]  phase_a_count,
    output logic      [`FTP_PHASE_B_W-1:0]  phase_b_count,
    output logic      [`FTP_PHASE_C_W-1:0]  phase_c_count,
    output logic      [`FTP_ERASE_W-1:0]    page_erase_count,
    output logic      [`FTP_ERASE_W-1:0]    bulk_erase_count
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    ftp_sel_type                sel;
    logic [`FTP_PHASE_A_W-1:0]  phase_a_r;
    logic [`FTP_PHASE_A_W-1:0]  phase_a_nxt;
    logic [`FTP_PHASE_B_W-1:0]  phase_b_r;
    logic [`FTP_PHASE_B_W-1:0]  phase_b_nxt;
    logic [`FTP_PHASE_C_W-1:0]  phase_c_r;
    logic [`FTP_PHASE_C_W-1:0]  phase_c_nxt;
    logic [`FTP_ERASE_W-1:0]    page_erase_r;
    logic [`FTP_ERASE_W-1:0]    page_erase_nxt;
    logic [`FTP_ERASE_W-1:0]    bulk_erase_r;
    logic [`FTP_ERASE_W-1:0]    bulk_erase_nxt;
    logic [`FTP_DATA_W-1:0]     rdata_r;
    logic [`FTP_DATA_W-1:0]     rdata_nxt;

    // one decode serves both strobes; they never come together
    assign sel = ftp_decode(reg_addr);

    // ------------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------------
    // only the low field bits are stored, so upper write data is dropped
    always_comb
    begin
        phase_a_nxt    = phase_a_r;
        phase_b_nxt    = phase_b_r;
        phase_c_nxt    = phase_c_r;
        page_erase_nxt = page_erase_r;
        bulk_erase_nxt = bulk_erase_r;
        if (reg_wr)
        begin
            case (sel)
                FTP_SEL_PHASE_A:
                    phase_a_nxt = reg_wdata[`FTP_PHASE_A_W-1:0];       // [RL1] [RL10]
                FTP_SEL_PHASE_B:
                    phase_b_nxt = reg_wdata[`FTP_PHASE_B_W-1:0];       // [RL3] [RL10]
                FTP_SEL_PHASE_C:
                    phase_c_nxt = reg_wdata[`FTP_PHASE_C_W-1:0];       // [RL5] [RL10]
                FTP_SEL_PAGE_ERASE:
                    page_erase_nxt = reg_wdata[`FTP_ERASE_W-1:0];      // [RL7] [RL10]
                FTP_SEL_BULK_ERASE:
                    bulk_erase_nxt = reg_wdata[`FTP_ERASE_W-1:0];      // [RL9] [RL10]
                default:
                    phase_a_nxt = phase_a_r;                           // unmapped write ignored
            endcase
        end
    end

    // reset values equal the 24 MHz oscillator settings
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_a_r    <= `FTP_RST_PHASE_A;     // [RL1]
            phase_b_r    <= `FTP_RST_PHASE_B;     // [RL3]
            phase_c_r    <= `FTP_RST_PHASE_C;     // [RL5]
            page_erase_r <= `FTP_RST_PAGE_ERASE;  // [RL7]
            bulk_erase_r <= `FTP_RST_BULK_ERASE;  // [RL9]
        end
        else
        begin
            phase_a_r    <= phase_a_nxt;
            phase_b_r    <= phase_b_nxt;
            phase_c_r    <= phase_c_nxt;
            page_erase_r <= page_erase_nxt;
            bulk_erase_r <= bulk_erase_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------------
    // read data stands for one cycle only and is zero otherwise, which also
    // answers unmapped addresses with zero
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd)
        begin
            case (sel)
                FTP_SEL_PHASE_A:
                    rdata_nxt = {{(`FTP_DATA_W-`FTP_PHASE_A_W){1'b0}}, phase_a_r};     // [RL1] [RL10]
                FTP_SEL_PHASE_B:
                    rdata_nxt = {{(`FTP_DATA_W-`FTP_PHASE_B_W){1'b0}}, phase_b_r};     // [RL3] [RL10]
                FTP_SEL_PHASE_C:
                    rdata_nxt = {{(`FTP_DATA_W-`FTP_PHASE_C_W){1'b0}}, phase_c_r};     // [RL5] [RL10]
                FTP_SEL_PAGE_ERASE:
                    rdata_nxt = {{(`FTP_DATA_W-`FTP_ERASE_W){1'b0}}, page_erase_r};    // [RL7] [RL10]
                FTP_SEL_BULK_ERASE:
                    rdata_nxt = {{(`FTP_DATA_W-`FTP_ERASE_W){1'b0}}, bulk_erase_r};    // [RL9] [RL10]
                default:
                    rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------------------
    // operation snapshot
    // ------------------------------------------------------------------------
    // the sequencer sees frozen copies, so a write mid-operation cannot stretch it
    ftp_snapshot u_snapshot
    (
        .core_clk         (core_clk),
        .reset_n          (reset_n),
        .op_start         (op_start),          // [RL11]
        .live_phase_a     (phase_a_r),
        .live_phase_b     (phase_b_r),
        .live_phase_c     (phase_c_r),
        .live_page_erase  (page_erase_r),
        .live_bulk_erase  (bulk_erase_r),
        .phase_a_count    (phase_a_count),
        .phase_b_count    (phase_b_count),
        .phase_c_count    (phase_c_count),
        .page_erase_count (page_erase_count),
        .bulk_erase_count (bulk_erase_count)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    phase_a_rw_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL1]
        (reg_wr && reg_addr == `FTP_OFS_PHASE_A) ##1 (reg_rd && reg_addr == `FTP_OFS_PHASE_A)
        |=> reg_rdata == {24'h000000, $past(reg_wdata[7:0], 2)})
        else $error("phase a readback differs from written value");

    phase_b_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL3]
        (reg_wr && reg_addr == `FTP_OFS_PHASE_B) |=> phase_b_r == $past(reg_wdata[10:0]))
        else $error("phase b write not stored");

    phase_c_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL5]
        (reg_rd && reg_addr == `FTP_OFS_PHASE_C) |=> reg_rdata == {24'h000000, $past(phase_c_r)})
        else $error("phase c read wrong");

    page_erase_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL7]
        !(reg_wr && reg_addr == `FTP_OFS_PAGE_ERASE) |=> $stable(page_erase_r))
        else $error("page erase count changed without a write");

    bulk_erase_rw_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL9]
        (reg_wr && reg_addr == `FTP_OFS_BULK_ERASE) ##1 (reg_rd && reg_addr == `FTP_OFS_BULK_ERASE)
        |=> reg_rdata == {15'h0000, $past(reg_wdata[16:0], 2)})
        else $error("bulk erase readback differs from written value");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL10]
        reg_rdata[31:17] == 15'h0000)
        else $error("reserved read bits not zero");

    read_slot_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL10]
        (!reg_rd || sel == FTP_SEL_NONE) |=> reg_rdata == 32'h00000000)
        else $error("read data outside its read slot");

    snap_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL11]
        (op_start && !reg_wr) ##1 (!op_start [*2]) |=> phase_c_count == $past(phase_c_r, 3))
        else $error("snapshot does not hold start-time value");

    // field by field: each count is written, held and read as its own word
    phase_a_write_a: assert property (  // [RL1]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && sel == FTP_SEL_PHASE_A) |=> phase_a_r == $past(reg_wdata[7:0]))
        else $error("phase a write not stored");

    phase_a_hold_a: assert property (  // [RL1]
        @(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && sel == FTP_SEL_PHASE_A) |=> $stable(phase_a_r))
        else $error("phase a changed without a write");

    phase_a_read_a: assert property (  // [RL1]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && sel == FTP_SEL_PHASE_A) |=> reg_rdata == {24'h000000, $past(phase_a_r)})
        else $error("phase a read wrong");

    phase_b_hold_a: assert property (  // [RL3]
        @(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && sel == FTP_SEL_PHASE_B) |=> $stable(phase_b_r))
        else $error("phase b changed without a write");

    phase_b_read_a: assert property (  // [RL3]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && sel == FTP_SEL_PHASE_B) |=> reg_rdata == {21'h00000, $past(phase_b_r)})
        else $error("phase b read wrong");

    phase_c_write_a: assert property (  // [RL5]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && sel == FTP_SEL_PHASE_C) |=> phase_c_r == $past(reg_wdata[7:0]))
        else $error("phase c write not stored");

    phase_c_hold_a: assert property (  // [RL5]
        @(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && sel == FTP_SEL_PHASE_C) |=> $stable(phase_c_r))
        else $error("phase c changed without a write");

    page_erase_write_a: assert property (  // [RL7]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && sel == FTP_SEL_PAGE_ERASE) |=> page_erase_r == $past(reg_wdata[16:0]))
        else $error("page erase write not stored");

    page_erase_read_a: assert property (  // [RL7]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && sel == FTP_SEL_PAGE_ERASE) |=> reg_rdata == {15'h0000, $past(page_erase_r)})
        else $error("page erase read wrong");

    bulk_erase_write_a: assert property (  // [RL9]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && sel == FTP_SEL_BULK_ERASE) |=> bulk_erase_r == $past(reg_wdata[16:0]))
        else $error("bulk erase write not stored");

    bulk_erase_hold_a: assert property (  // [RL9]
        @(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && sel == FTP_SEL_BULK_ERASE) |=> $stable(bulk_erase_r))
        else $error("bulk erase changed without a write");

    bulk_erase_read_a: assert property (  // [RL9]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && sel == FTP_SEL_BULK_ERASE) |=> reg_rdata == {15'h0000, $past(bulk_erase_r)})
        else $error("bulk erase read wrong");

    narrow_upper_a: assert property (  // [RL10]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && (sel == FTP_SEL_PHASE_A || sel == FTP_SEL_PHASE_C)) |=> reg_rdata[31:8] == 24'h000000)
        else $error("8-bit field upper bits not zero");

    phase_b_upper_a: assert property (  // [RL10]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && sel == FTP_SEL_PHASE_B) |=> reg_rdata[31:11] == 21'h00000)
        else $error("phase b upper bits not zero");

    unmapped_write_a: assert property (  // [RL10]
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && sel == FTP_SEL_NONE) |=> $stable(phase_a_r) && $stable(phase_c_r) && $stable(bulk_erase_r))
        else $error("unmapped write changed a count");

    write_quiet_a: assert property (  // [RL10]
        @(posedge core_clk) disable iff (!reset_n)
        reg_wr |=> reg_rdata == 32'h00000000)
        else $error("write answered on read data");

    snap_start_a: assert property (  // [RL11]
        @(posedge core_clk) disable iff (!reset_n)
        op_start |=> (phase_a_count == $past(phase_a_r)) && (bulk_erase_count == $past(bulk_erase_r)))
        else $error("start did not capture counts");

    snap_still_a: assert property (  // [RL11]
        @(posedge core_clk) disable iff (!reset_n)
        !op_start |=> $stable(phase_b_count) && $stable(phase_c_count) && $stable(page_erase_count))
        else $error("counts moved without a start");

    snap_old_a: assert property (  // [RL11]
        @(posedge core_clk) disable iff (!reset_n)
        (op_start && reg_wr && sel == FTP_SEL_PAGE_ERASE) |=> page_erase_count == $past(page_erase_r))
        else $error("start took the value written with it");

endmodule // ftp_regs

`default_nettype wire

// file: rtl/ftp_consts.svh
/*
 * Offsets, field widths and reset values of the flash timing parameter bank.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef FTP_CONSTS_SVH
`define FTP_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets (12-bit register address space)
// ----------------------------------------------------------------------------
`define FTP_ADDR_W          12
`define FTP_OFS_PHASE_A     12'h108
`define FTP_OFS_PHASE_B     12'h10c
`define FTP_OFS_PHASE_C     12'h110
`define FTP_OFS_PAGE_ERASE  12'h114
`define FTP_OFS_BULK_ERASE  12'h118

// ----------------------------------------------------------------------------
// field widths, all fields start at bit 0
// ----------------------------------------------------------------------------
`define FTP_PHASE_A_W       8
`define FTP_PHASE_B_W       11
`define FTP_PHASE_C_W       8
`define FTP_ERASE_W         17
`define FTP_DATA_W          32

// ----------------------------------------------------------------------------
// reset values (24 MHz oscillator settings)
// ----------------------------------------------------------------------------
`define FTP_RST_PHASE_A     8'hb4
`define FTP_RST_PHASE_B     11'h6c0
`define FTP_RST_PHASE_C     8'hb4
`define FTP_RST_PAGE_ERASE  17'h11940
`define FTP_RST_BULK_ERASE  17'h11940

`endif

// file: rtl/ftp_pkg.sv
/*
 * Types and the address decode function of the flash timing parameter bank.
 * Assumes ftp_consts.svh is on the include path.
 */
`include "ftp_consts.svh"

package ftp_pkg;

    // ------------------------------------------------------------------------
    // register select
    // ------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        FTP_SEL_NONE,
        FTP_SEL_PHASE_A,
        FTP_SEL_PHASE_B,
        FTP_SEL_PHASE_C,
        FTP_SEL_PAGE_ERASE,
        FTP_SEL_BULK_ERASE
    } ftp_sel_type;

    // decode shared by the write path and the read path
    function automatic ftp_sel_type ftp_decode(input logic [`FTP_ADDR_W-1:0] addr);
        ftp_sel_type sel;
        sel = FTP_SEL_NONE;
        case (addr)
            `FTP_OFS_PHASE_A:    sel = FTP_SEL_PHASE_A;
            `FTP_OFS_PHASE_B:    sel = FTP_SEL_PHASE_B;
            `FTP_OFS_PHASE_C:    sel = FTP_SEL_PHASE_C;
            `FTP_OFS_PAGE_ERASE: sel = FTP_SEL_PAGE_ERASE;
            `FTP_OFS_BULK_ERASE: sel = FTP_SEL_BULK_ERASE;
            default:             sel = FTP_SEL_NONE;
        endcase
        return sel;
    endfunction

endpackage

// file: rtl/ftp_snapshot.sv
/*
 * Snapshot of the five timing counts, taken when a flash operation starts.
 * Assumes op_start is a one-cycle pulse from logic on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftp_consts.svh"

module ftp_snapshot
    import ftp_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic                       op_start,
    input  wire logic [`FTP_PHASE_A_W-1:0]  live_phase_a,
    input  wire logic [`FTP_PHASE_B_W-1:0]  live_phase_b,
    input  wire logic [`FTP_PHASE_C_W-1:0]  live_phase_c,
    input  wire logic [`FTP_ERASE_W-1:0]    live_page_erase,
    input  wire logic [`FTP_ERASE_W-1:0]    live_bulk_erase,
    output logic      [`FTP_PHASE_A_W-1:0]  phase_a_count,
    output logic      [`FTP_PHASE_B_W-1:0]  phase_b_count,
    output logic      [`FTP_PHASE_C_W-1:0]  phase_c_count,
    output logic      [`FTP_ERASE_W-1:0]    page_erase_count,
    output logic      [`FTP_ERASE_W-1:0]    bulk_erase_count
);

    logic [`FTP_PHASE_A_W-1:0]  snap_a_r;
    logic [`FTP_PHASE_A_W-1:0]  snap_a_nxt;
    logic [`FTP_PHASE_B_W-1:0]  snap_b_r;
    logic [`FTP_PHASE_B_W-1:0]  snap_b_nxt;
    logic [`FTP_PHASE_C_W-1:0]  snap_c_r;
    logic [`FTP_PHASE_C_W-1:0]  snap_c_nxt;
    logic [`FTP_ERASE_W-1:0]    snap_pe_r;
    logic [`FTP_ERASE_W-1:0]    snap_pe_nxt;
    logic [`FTP_ERASE_W-1:0]    snap_be_r;
    logic [`FTP_ERASE_W-1:0]    snap_be_nxt;

    // ------------------------------------------------------------------------
    // capture
    // ------------------------------------------------------------------------
    // a running operation keeps its durations even if software rewrites the bank
    always_comb
    begin
        snap_a_nxt  = snap_a_r;
        snap_b_nxt  = snap_b_r;
        snap_c_nxt  = snap_c_r;
        snap_pe_nxt = snap_pe_r;
        snap_be_nxt = snap_be_r;
        if (op_start)
        begin
            snap_a_nxt  = live_phase_a;     // [RL11]
            snap_b_nxt  = live_phase_b;     // [RL11]
            snap_c_nxt  = live_phase_c;     // [RL11]
            snap_pe_nxt = live_page_erase;  // [RL11]
            snap_be_nxt = live_bulk_erase;  // [RL11]
        end
    end

    // registers take the reset values so the outputs are sane before any start
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            snap_a_r  <= `FTP_RST_PHASE_A;
            snap_b_r  <= `FTP_RST_PHASE_B;
            snap_c_r  <= `FTP_RST_PHASE_C;
            snap_pe_r <= `FTP_RST_PAGE_ERASE;
            snap_be_r <= `FTP_RST_BULK_ERASE;
        end
        else
        begin
            snap_a_r  <= snap_a_nxt;
            snap_b_r  <= snap_b_nxt;
            snap_c_r  <= snap_c_nxt;
            snap_pe_r <= snap_pe_nxt;
            snap_be_r <= snap_be_nxt;
        end
    end

    assign phase_a_count    = snap_a_r;
    assign phase_b_count    = snap_b_r;
    assign phase_c_count    = snap_c_r;
    assign page_erase_count = snap_pe_r;
    assign bulk_erase_count = snap_be_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    snap_capture_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL11]
        op_start |=> (page_erase_count == $past(live_page_erase))
                     && (phase_b_count == $past(live_phase_b)))
        else $error("snapshot did not capture live counts");

    snap_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [RL11]
        !op_start |=> $stable(bulk_erase_count) && $stable(phase_a_count))
        else $error("snapshot changed without an operation start");

endmodule // ftp_snapshot

`default_nettype wire

// file: verification/ftp_regs_tb.sv
/*
 * Self-checking bench for the flash timing parameter bank.
 * Assumes ftp_pkg and ftp_consts.svh are compiled first; drives ports directly.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftp_consts.svh"

module ftp_regs_tb;
    import ftp_pkg::*;

    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        op_start = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  phase_a_count;
    logic [10:0] phase_b_count;
    logic [7:0]  phase_c_count;
    logic [16:0] page_erase_count;
    logic [16:0] bulk_erase_count;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;

    // per-frequency settings: 4, 8, 16, 22.12, 24 MHz
    logic [31:0] tab_a [5] = '{32'h1e, 32'h3c, 32'h78, 32'ha6, 32'hb4};
    logic [31:0] tab_b [5] = '{32'h120, 32'h240, 32'h480, 32'h639, 32'h6c0};
    logic [31:0] tab_e [5] = '{32'h2ee0, 32'h5dc0, 32'hbb80, 32'h10338, 32'h11940};

    // ------------------------------------------------------------------------
    // clock, timeout and dut
    // ------------------------------------------------------------------------
    always #50 core_clk = ~core_clk;

    // ceiling well above the roughly 150 cycles the scenarios need
    always @(posedge core_clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000)
        begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end

    ftp_regs dut (
        .core_clk         (core_clk),
        .reset_n          (reset_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .op_start         (op_start),
        .phase_a_count    (phase_a_count),
        .phase_b_count    (phase_b_count),
        .phase_c_count    (phase_c_count),
        .page_erase_count (page_erase_count),
        .bulk_erase_count (bulk_erase_count)
    );

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // every input is assigned once per cycle, so back-to-back strobes never race
    task automatic cyc(input logic wr, input logic rd, input logic op, input logic [11:0] a,
                       input logic [31:0] d);
        reg_wr    <= wr;
        reg_rd    <= rd;
        op_start  <= op;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask

    // read data stands only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        cyc(1'b0, 1'b1, 1'b0, a, 32'h0);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(what, reg_rdata, exp);
        @(posedge core_clk);
    endtask

    task automatic counts_chk(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                              input logic [31:0] pe, input logic [31:0] be);
        @(negedge core_clk);
        check("phase_a_count", {24'h0, phase_a_count}, a);
        check("phase_b_count", {21'h0, phase_b_count}, b);
        check("phase_c_count", {24'h0, phase_c_count}, c);
        check("page_erase_count", {15'h0, page_erase_count}, pe);
        check("bulk_erase_count", {15'h0, bulk_erase_count}, be);
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // reset contents of every register and of the snapshot outputs
    task automatic test_reset_values();
        rd_chk("phase_a reset", `FTP_OFS_PHASE_A, 32'hb4);
        rd_chk("phase_b reset", `FTP_OFS_PHASE_B, 32'h6c0);
        rd_chk("phase_c reset", `FTP_OFS_PHASE_C, 32'hb4);
        rd_chk("page reset", `FTP_OFS_PAGE_ERASE, 32'h11940);
        rd_chk("bulk reset", `FTP_OFS_BULK_ERASE, 32'h11940);
        counts_chk(32'hb4, 32'h6c0, 32'hb4, 32'h11940, 32'h11940);
    endtask

    // all-ones writes back to back: only field bits may stick
    task automatic test_reserved_bits();
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_A, 32'hffffffff);
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_B, 32'hffffffff);
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_C, 32'hffffffff);
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PAGE_ERASE, 32'hffffffff);
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_BULK_ERASE, 32'hffffffff);
        rd_chk("phase_a mask", `FTP_OFS_PHASE_A, 32'hff);
        rd_chk("phase_b mask", `FTP_OFS_PHASE_B, 32'h7ff);
        rd_chk("phase_c mask", `FTP_OFS_PHASE_C, 32'hff);
        rd_chk("page mask", `FTP_OFS_PAGE_ERASE, 32'h1ffff);
        rd_chk("bulk mask", `FTP_OFS_BULK_ERASE, 32'h1ffff);
    endtask

    // unmapped and aliased addresses neither store nor answer
    task automatic test_unmapped();
        cyc(1'b1, 1'b0, 1'b0, 12'h908, 32'h0);
        cyc(1'b1, 1'b0, 1'b0, 12'h11c, 32'h0);
        rd_chk("alias of phase_a", 12'h908, 32'h0);
        rd_chk("unmapped 0x11c", 12'h11c, 32'h0);
        rd_chk("unmapped 0x104", 12'h104, 32'h0);
        rd_chk("phase_a after alias write", `FTP_OFS_PHASE_A, 32'hff);
    endtask

    // every documented oscillator setting stored, read back and snapshotted
    task automatic test_freq_table();
        for (int i = 0; i < 5; i++)
        begin
            cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_A, tab_a[i]);
            cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_B, tab_b[i]);
            cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_C, tab_a[i]);
            cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PAGE_ERASE, tab_e[i]);
            cyc(1'b1, 1'b0, 1'b1, `FTP_OFS_BULK_ERASE, tab_e[i]);
            rd_chk("phase_a table", `FTP_OFS_PHASE_A, tab_a[i]);
            rd_chk("phase_b table", `FTP_OFS_PHASE_B, tab_b[i]);
            rd_chk("phase_c table", `FTP_OFS_PHASE_C, tab_a[i]);
            rd_chk("page table", `FTP_OFS_PAGE_ERASE, tab_e[i]);
            rd_chk("bulk table", `FTP_OFS_BULK_ERASE, tab_e[i]);
            cyc(1'b0, 1'b0, 1'b1, 12'h000, 32'h0);
            cyc(1'b0, 1'b0, 1'b0, 12'h000, 32'h0);
            counts_chk(tab_a[i], tab_b[i], tab_a[i], tab_e[i], tab_e[i]);
        end
    endtask

    // a write in the start cycle is not seen until the next start
    task automatic test_snapshot_hold();
        cyc(1'b1, 1'b0, 1'b1, `FTP_OFS_PAGE_ERASE, 32'h2ee0);
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_B, 32'h120);
        cyc(1'b0, 1'b0, 1'b0, 12'h000, 32'h0);
        counts_chk(32'hb4, 32'h6c0, 32'hb4, 32'h11940, 32'h11940);
        cyc(1'b0, 1'b0, 1'b1, 12'h000, 32'h0);
        cyc(1'b0, 1'b0, 1'b0, 12'h000, 32'h0);
        counts_chk(32'hb4, 32'h120, 32'hb4, 32'h2ee0, 32'h11940);
    endtask

    // read strobe right after the write strobe, no idle cycle between
    task automatic test_back_to_back();
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_PHASE_A, 32'h5a5a5a3c);
        rd_chk("phase_a back to back", `FTP_OFS_PHASE_A, 32'h3c);
        cyc(1'b1, 1'b0, 1'b0, `FTP_OFS_BULK_ERASE, 32'hfffe2ee0);
        rd_chk("bulk back to back", `FTP_OFS_BULK_ERASE, 32'h2ee0);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        test_reset_values();
        test_reserved_bits();
        test_unmapped();
        test_freq_table();
        test_snapshot_hold();
        test_back_to_back();
        stop_test();
    end

endmodule // ftp_regs_tb
`default_nettype wire
